// file: common/pmg_pkg.sv
// shared constants and types of the pwm/pdm generator
package pmg_pkg;

  // ----------------------------------------
  // channel count and data widths
  // ----------------------------------------
  localparam int NUM_CHAN = 8;
  localparam int CMD_W = 16;
  localparam int SCALE_W = 16;
  localparam int SCALE_FRAC = 8;
  localparam int DUTY_W = 16;
  localparam int PER_W = 24;
  localparam int PER_FRAC = 8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 10000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int UPDATE_TICKS = 100;
  localparam int MIN_PERIOD_TICKS = 2;
  localparam logic [PER_W-1:0] PERIOD_MIN = PER_W'(MIN_PERIOD_TICKS << PER_FRAC);

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    PMG_VAR_SINGLE = 2'h0,
    PMG_VAR_SIGN = 2'h1,
    PMG_VAR_SPLIT = 2'h2
  } pmg_variant_e;

  typedef enum logic [0:0] {
    PMG_DIV_IDLE = 1'h0,
    PMG_DIV_RUN = 1'h1
  } pmg_div_e;

endpackage

// file: rtl/pmg_div.sv
// serial divider giving high ticks over period ticks as a duty fraction
`timescale 1ns/100ps
module pmg_div
  import pmg_pkg::*;
#(
  parameter int W = DUTY_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // request
  input wire logic start,
  input wire logic [W-1:0] numer,
  input wire logic [W-1:0] denom,
  // answer
  output logic [W-1:0] quotient,
  output logic done
);

  localparam int SW = $clog2(W + 1);

  typedef struct packed {
    pmg_div_e state;
    logic [SW-1:0] step;
    logic [W+1:0] rem;
    logic [W:0] quo;
    logic [W-1:0] res;
    logic done;
  } pmg_div_s;

  pmg_div_s st_q;
  pmg_div_s st_d;

  // ----------------------------------------
  // restoring division, one quotient bit per cycle
  // ----------------------------------------
  always_comb begin
    logic bitQ;
    bitQ = 1'b0;
    st_d = st_q;
    st_d.done = 1'b0;
    unique case (st_q.state)
      PMG_DIV_IDLE: begin
        if (start) begin
          st_d.state = PMG_DIV_RUN;
          st_d.rem = (W + 2)'(numer);
          st_d.quo = '0;
          st_d.step = '0;
        end
      end
      PMG_DIV_RUN: begin
        if (st_q.rem >= {2'h0, denom}) begin
          st_d.rem = st_q.rem - {2'h0, denom};
          bitQ = 1'b1;
        end
        st_d.quo = {st_q.quo[W-1:0], bitQ};
        st_d.rem = {st_d.rem[W:0], 1'b0};
        st_d.step = st_q.step + SW'(1);
        if (st_q.step == SW'(W)) begin
          st_d.state = PMG_DIV_IDLE;
          st_d.done = 1'b1;
          st_d.res = st_d.quo[W] ? '1 : st_d.quo[W-1:0];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign quotient = st_q.res;
  assign done = st_q.done;

endmodule

// file: rtl/pmg_gen.sv
// eight-channel pwm/pdm generator with tick-rate waveforms and slow update
`timescale 1ns/100ps
// Operation
// - eight channels share one tick and update
// - variants: single, with sign, split pair
// - single variant treats negative command as zero
// - zeroed negative still lifted to duty floor
// - sign variant uses command magnitude
// - sign output low positive, high negative
// - split positive: wave on up, down low
// - split negative: wave on down, up low
// - command times per-channel scale gives duty
// - per-channel enable gates pwm, up and down outputs; dir keeps last sign
// - disabled channel duty is zero, ignoring floor
// - duty clamped between floor and ceiling
// - zero carrier request selects density modulation
// - too-fast carrier limited at next update
// - no dither: period rounded to whole ticks
// - dither varies periods to reach fractional averages
// - no dither: period and duty exact ticks
// - report applied duty after limiting and rounding
// - fast tick waveform, slower update step
// - tick period sets carrier limit, resolution
module pmg_gen
  import pmg_pkg::*;
#(
  parameter int NCHAN = NUM_CHAN,
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int UPD_TICKS = UPDATE_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // per-channel command and configuration
  input wire logic [NCHAN-1:0][CMD_W-1:0] cmdValue,
  input wire logic [NCHAN-1:0][SCALE_W-1:0] cmdScale,
  input wire logic [NCHAN-1:0][1:0] outVariant,
  input wire logic [NCHAN-1:0] chanEnable,
  input wire logic [NCHAN-1:0] ditherEnable,
  input wire logic [NCHAN-1:0][PER_W-1:0] carrierPeriod,
  input wire logic [NCHAN-1:0][DUTY_W-1:0] dutyFloor,
  input wire logic [NCHAN-1:0][DUTY_W-1:0] dutyCeiling,
  // waveform outputs
  output logic [NCHAN-1:0] pwmOut,
  output logic [NCHAN-1:0] dirOut,
  output logic [NCHAN-1:0] upOut,
  output logic [NCHAN-1:0] downOut,
  // status
  output logic [NCHAN-1:0][DUTY_W-1:0] appliedDutyReport,
  output logic fastTick,
  output logic slowUpdate
);

  localparam int TCW = $clog2(TICK_CYC);
  localparam int UCW = $clog2(UPD_TICKS) + 1;

  typedef struct packed {
    logic [TCW-1:0] tickCnt;
    logic [UCW-1:0] updCnt;
    logic tick;
    logic upd;
    logic updD;
    logic [NCHAN-1:0][DUTY_W-1:0] duty;
    logic [NCHAN-1:0][15:0] perInt;
    logic [NCHAN-1:0][7:0] perFrac;
    logic [NCHAN-1:0][15:0] hiInt;
    logic [NCHAN-1:0][7:0] hiFrac;
    logic [NCHAN-1:0] pdm;
    logic [NCHAN-1:0] neg;
    logic [NCHAN-1:0] exact;
    logic [NCHAN-1:0][15:0] cnt;
    logic [NCHAN-1:0][15:0] curPer;
    logic [NCHAN-1:0][15:0] curHi;
    logic [NCHAN-1:0][7:0] perAcc;
    logic [NCHAN-1:0][7:0] hiAcc;
    logic [NCHAN-1:0][DUTY_W-1:0] dAcc;
    logic [NCHAN-1:0] pwm;
    logic [NCHAN-1:0] dir;
    logic [NCHAN-1:0] up;
    logic [NCHAN-1:0] dn;
    logic [NCHAN-1:0][DUTY_W-1:0] report;
  } pmg_state_s;

  pmg_state_s st_q;
  pmg_state_s st_d;
  logic [NCHAN-1:0][DUTY_W-1:0] divQuo;
  logic [NCHAN-1:0] divDone;

  // ----------------------------------------
  // duty report dividers, one per channel
  // ----------------------------------------
  for (genvar g = 0; g < NCHAN; g++) begin : gDiv
    pmg_div #(.W(DUTY_W)) uDiv (
      .clk(clk),
      .srst(srst),
      .start(st_q.updD),
      .numer(st_q.hiInt[g]),
      .denom(st_q.perInt[g]),
      .quotient(divQuo[g]),
      .done(divDone[g])
    );
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [16:0] ext;
    logic [16:0] mag;
    logic [32:0] prod;
    logic [DUTY_W-1:0] req;
    logic [PER_W-1:0] per;
    logic [31:0] hp0;
    logic [39:0] hp1;
    logic [8:0] sumP;
    logic [8:0] sumH;
    logic [DUTY_W:0] sumD;
    logic [15:0] nP;
    logic [15:0] nH;
    logic wave;
    ext = '0;
    mag = '0;
    prod = '0;
    req = DUTY_RST;
    per = '0;
    hp0 = '0;
    hp1 = '0;
    sumP = '0;
    sumH = '0;
    sumD = '0;
    nP = '0;
    nH = '0;
    wave = 1'b0;
    st_d = st_q;
    st_d.tick = (st_q.tickCnt == TCW'(TICK_CYC - 1));
    st_d.tickCnt = st_d.tick ? '0 : st_q.tickCnt + TCW'(1);
    st_d.upd = st_q.tick && (st_q.updCnt == UCW'(UPD_TICKS - 1));
    if (st_q.tick) begin
      st_d.updCnt = st_d.upd ? '0 : st_q.updCnt + UCW'(1);
    end
    st_d.updD = st_q.upd;
    for (int i = 0; i < NCHAN; i++) begin
      // slow step: scale, clamp, round
      if (st_q.upd) begin
        ext = {cmdValue[i][CMD_W-1], cmdValue[i]};
        mag = ext[16] ? 17'(-ext) : ext;
        if (outVariant[i] == PMG_VAR_SINGLE && ext[16]) begin
          mag = '0;
        end
        prod = 33'(mag) * 33'(cmdScale[i]);
        req = (|prod[32:24]) ? '1 : prod[23:SCALE_FRAC];
        if (req < dutyFloor[i]) begin
          req = dutyFloor[i];
        end
        if (req > dutyCeiling[i]) begin
          req = dutyCeiling[i];
        end
        if (!chanEnable[i]) begin
          req = '0;
        end
        st_d.duty[i] = req;
        if (chanEnable[i]) begin
          st_d.neg[i] = ext[16];
        end
        per = carrierPeriod[i];
        st_d.pdm[i] = (per == '0);
        if (per != '0 && per < PERIOD_MIN) begin
          per = PERIOD_MIN;
        end
        if (ditherEnable[i]) begin
          st_d.perInt[i] = per[PER_W-1:PER_FRAC];
          st_d.perFrac[i] = per[PER_FRAC-1:0];
          hp1 = 40'(req) * 40'(per);
          st_d.hiInt[i] = hp1[39:24];
          st_d.hiFrac[i] = hp1[23:16];
        end else begin
          st_d.perInt[i] = per[PER_W-1:PER_FRAC];
          if (per[PER_W-1:PER_FRAC] != 16'hffff) begin
            st_d.perInt[i] = per[PER_W-1:PER_FRAC] + 16'(per[PER_FRAC-1]);
          end
          st_d.perFrac[i] = '0;
          hp0 = 32'(req) * 32'(st_d.perInt[i]);
          st_d.hiInt[i] = hp0[31:16] + 16'(hp0[15]);
          st_d.hiFrac[i] = '0;
        end
        st_d.exact[i] = !ditherEnable[i] && (carrierPeriod[i] != '0);
      end
      // fast step: waveform
      if (st_q.tick) begin
        if (!chanEnable[i]) begin
          st_d.cnt[i] = '0;
          wave = 1'b0;
        end else if (st_q.pdm[i]) begin
          sumD = {1'b0, st_q.dAcc[i]} + {1'b0, st_q.duty[i]};
          st_d.dAcc[i] = sumD[DUTY_W-1:0];
          wave = sumD[DUTY_W];
        end else if (st_q.cnt[i] == '0) begin
          sumP = {1'b0, st_q.perAcc[i]} + {1'b0, st_q.perFrac[i]};
          sumH = {1'b0, st_q.hiAcc[i]} + {1'b0, st_q.hiFrac[i]};
          nP = (&st_q.perInt[i]) ? st_q.perInt[i] : st_q.perInt[i] + 16'(sumP[8]);
          nH = st_q.hiInt[i] + 16'(sumH[8]);
          st_d.perAcc[i] = sumP[7:0];
          st_d.hiAcc[i] = sumH[7:0];
          st_d.curPer[i] = nP;
          st_d.curHi[i] = nH;
          wave = (nH != '0);
          st_d.cnt[i] = (nP > 16'h0001) ? 16'h0001 : 16'h0000;
        end else begin
          wave = (st_q.cnt[i] < st_q.curHi[i]);
          st_d.cnt[i] = (st_q.cnt[i] + 16'h0001 == st_q.curPer[i]) ? 16'h0000 : st_q.cnt[i] + 16'h0001;
        end
        st_d.pwm[i] = wave && (outVariant[i] != PMG_VAR_SPLIT);
        st_d.dir[i] = (outVariant[i] == PMG_VAR_SIGN) && st_q.neg[i];
        st_d.up[i] = wave && (outVariant[i] == PMG_VAR_SPLIT) && !st_q.neg[i];
        st_d.dn[i] = wave && (outVariant[i] == PMG_VAR_SPLIT) && st_q.neg[i];
      end
      // applied duty report
      if (st_q.updD && !st_q.exact[i]) begin
        st_d.report[i] = st_q.duty[i];
      end
      if (divDone[i] && st_q.exact[i]) begin
        st_d.report[i] = divQuo[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pwmOut = st_q.pwm;
  assign dirOut = st_q.dir;
  assign upOut = st_q.up;
  assign downOut = st_q.dn;
  assign appliedDutyReport = st_q.report;
  assign fastTick = st_q.tick;
  assign slowUpdate = st_q.upd;

  // ----------------------------------------
  // checks on channel 0, plus tick and update timing and split legs of all channels
  // ----------------------------------------
  default clocking cbk @(posedge clk); endclocking
  default disable iff (srst);

  chk_tick_gap: assert property (st_q.tick |=> !st_q.tick [*8])
    else $error("fast tick repeated too soon");
  chk_upd_on_tick: assert property (st_q.upd |-> $past(st_q.tick) && !st_q.tick)
    else $error("update not one cycle after a tick");
  chk_neg_floor: assert property (st_q.upd && chanEnable[0] && outVariant[0] == PMG_VAR_SINGLE
      && cmdValue[0][CMD_W-1] && dutyFloor[0] <= dutyCeiling[0] |=> st_q.duty[0] == $past(dutyFloor[0]))
    else $error("negative single command not floored");
  chk_dis_zero: assert property (st_q.upd && !chanEnable[0] |=> st_q.duty[0] == '0)
    else $error("disabled duty not zero");
  chk_clamp: assert property (st_q.upd && chanEnable[0] && dutyFloor[0] <= dutyCeiling[0]
      |=> st_q.duty[0] >= $past(dutyFloor[0]) && st_q.duty[0] <= $past(dutyCeiling[0]))
    else $error("duty outside floor and ceiling");
  chk_sign_track: assert property (st_q.upd && chanEnable[0] |=> st_q.neg[0] == $past(cmdValue[0][CMD_W-1]))
    else $error("sign does not follow command");
  chk_dis_low: assert property (st_q.tick && !chanEnable[0] |=> !pwmOut[0] && !upOut[0] && !downOut[0])
    else $error("disabled channel drives waveform");
  chk_split_pos: assert property (st_q.tick |=> (downOut & ~$past(st_q.neg)) == '0)
    else $error("down active for positive command");
  chk_split_neg: assert property (st_q.tick |=> (upOut & $past(st_q.neg)) == '0)
    else $error("up active for negative command");
  chk_pdm_select: assert property (st_q.upd && carrierPeriod[0] == '0 |=> st_q.pdm[0])
    else $error("zero carrier did not select density mode");
  chk_period_limit: assert property (st_q.upd && carrierPeriod[0] != '0
      |=> st_q.perInt[0] >= 16'(MIN_PERIOD_TICKS))
    else $error("carrier period below limit");
  chk_round_per: assert property (st_q.upd && !ditherEnable[0] && carrierPeriod[0] >= PERIOD_MIN
      && carrierPeriod[0][PER_W-1:PER_FRAC] != 16'hffff
      |=> st_q.perInt[0] == $past(carrierPeriod[0][PER_W-1:PER_FRAC]) + 16'($past(carrierPeriod[0][PER_FRAC-1]))
      && st_q.perFrac[0] == '0)
    else $error("period not rounded to whole ticks");
  chk_report_time: assert property (st_q.updD && st_q.exact[0] |-> ##[1:20] divDone[0])
    else $error("duty report not refreshed in time");

  cov_pdm_pulse: cover property (st_q.pdm[0] && pwmOut[0]);
  cov_dither_run: cover property (ditherEnable[0] && st_q.tick && st_q.cnt[0] == '0 && chanEnable[0]);
  cov_split_neg: cover property (downOut[0]);
  cov_sign_high: cover property (dirOut[0]);

endmodule

// file: verif/pmg_bridge_model.sv
// power bridge model counting driven leg ticks per channel
`timescale 1ns/100ps
module pmg_bridge_model
  import pmg_pkg::*;
(
  // clock and tick
  input wire logic clk,
  input wire logic srst,
  input wire logic fastTick,
  // bridge legs
  input wire logic [NUM_CHAN-1:0] upOut,
  input wire logic [NUM_CHAN-1:0] downOut,
  // observed
  output int upTicks [NUM_CHAN],
  output int downTicks [NUM_CHAN],
  output logic shootThrough
);
  // ----------------------------------------
  // leg counters and overlap flag
  // ----------------------------------------
  always @(posedge clk) begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (srst) begin
        upTicks[i] <= 0;
        downTicks[i] <= 0;
      end else if (fastTick) begin
        upTicks[i] <= upTicks[i] + int'(upOut[i]);
        downTicks[i] <= downTicks[i] + int'(downOut[i]);
      end
    end
    if (srst) begin
      shootThrough <= 1'b0;
    end else if ((upOut & downOut) != '0) begin
      shootThrough <= 1'b1;
    end
  end
endmodule

// file: verif/multi_channel_pwm_pdm_generator_bench.sv
// self-checking bench of the pwm/pdm generator
`timescale 1ns/100ps
module multi_channel_pwm_pdm_generator_bench;
  import pmg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int TC = 16;
  localparam int UT = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [NUM_CHAN-1:0][CMD_W-1:0] cmdValue = '0;
  logic [NUM_CHAN-1:0][SCALE_W-1:0] cmdScale = '0;
  logic [NUM_CHAN-1:0][1:0] outVariant = '0;
  logic [NUM_CHAN-1:0] chanEnable = '0;
  logic [NUM_CHAN-1:0] ditherEnable = '0;
  logic [NUM_CHAN-1:0][PER_W-1:0] carrierPeriod = '0;
  logic [NUM_CHAN-1:0][DUTY_W-1:0] dutyFloor = '0;
  logic [NUM_CHAN-1:0][DUTY_W-1:0] dutyCeiling = '0;
  logic [NUM_CHAN-1:0] pwmOut, dirOut, upOut, downOut;
  logic [NUM_CHAN-1:0][DUTY_W-1:0] appliedDutyReport;
  logic fastTick, slowUpdate, shootThrough;
  int upTicks [NUM_CHAN];
  int downTicks [NUM_CHAN];
  int pwmTicks [NUM_CHAN];
  int upBase [NUM_CHAN];
  int dnBase [NUM_CHAN];
  int fail_count = 0;
  int cmp_count = 0;

  pmg_gen #(.NCHAN(NUM_CHAN), .TICK_CYC(TC), .UPD_TICKS(UT)) i_dut (.clk(clk), .srst(srst),
    .cmdValue(cmdValue), .cmdScale(cmdScale), .outVariant(outVariant), .chanEnable(chanEnable),
    .ditherEnable(ditherEnable), .carrierPeriod(carrierPeriod), .dutyFloor(dutyFloor),
    .dutyCeiling(dutyCeiling), .pwmOut(pwmOut), .dirOut(dirOut), .upOut(upOut), .downOut(downOut),
    .appliedDutyReport(appliedDutyReport), .fastTick(fastTick), .slowUpdate(slowUpdate));
  pmg_bridge_model i_bridge (.clk(clk), .srst(srst), .fastTick(fastTick), .upOut(upOut),
    .downOut(downOut), .upTicks(upTicks), .downTicks(downTicks), .shootThrough(shootThrough));

  initial forever #4 clk = ~clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task set_chan(input int ch, input logic [1:0] v, input logic [15:0] c, input logic [15:0] s,
                input logic [23:0] p, input logic [15:0] fl, input logic [15:0] ce, input logic d);
    @(posedge clk);
    outVariant[ch] <= v;
    cmdValue[ch] <= c;
    cmdScale[ch] <= s;
    carrierPeriod[ch] <= p;
    dutyFloor[ch] <= fl;
    dutyCeiling[ch] <= ce;
    ditherEnable[ch] <= d;
  endtask

  task wait_upd(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (slowUpdate !== 1'b1 && t < 200);
      if (slowUpdate !== 1'b1) begin
        fail_count++;
        end_sim();
      end
    end
  endtask

  task measure(input int nt);
    int t;
    t = 0;
    @(negedge clk);
    for (int i = 0; i < NUM_CHAN; i++) begin
      pwmTicks[i] = 0;
      upBase[i] = upTicks[i];
      dnBase[i] = downTicks[i];
    end
    while (nt > 0 && t < 4000) begin
      @(negedge clk);
      t++;
      if (fastTick === 1'b1) begin
        nt--;
        for (int i = 0; i < NUM_CHAN; i++) pwmTicks[i] += int'(pwmOut[i]);
      end
    end
    if (nt > 0) begin
      fail_count++;
      end_sim();
    end
    // let the bridge model count the last tick
    @(negedge clk);
  endtask

  task chk_chan(input int ch, input int ep, input int eu, input int ed, input logic edir,
                input logic [15:0] er);
    check(pwmTicks[ch], ep);
    check(upTicks[ch] - upBase[ch], eu);
    check(downTicks[ch] - dnBase[ch], ed);
    check(dirOut[ch], edir);
    check(appliedDutyReport[ch], er);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    check({pwmOut, dirOut, upOut, downOut}, 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    set_chan(0, 2'h0, 16'h6666, 16'h0100, 24'h000a00, 16'h0000, 16'hffff, 1'b0);
    set_chan(1, 2'h0, 16'h8000, 16'h0100, 24'h000a00, 16'h3333, 16'hffff, 1'b0);
    set_chan(2, 2'h1, 16'h999a, 16'h0100, 24'h000a00, 16'h0000, 16'hffff, 1'b0);
    set_chan(3, 2'h1, 16'h2000, 16'h0100, 24'h000a00, 16'h0000, 16'hffff, 1'b0);
    set_chan(4, 2'h2, 16'h6666, 16'h0100, 24'h000a00, 16'h0000, 16'hffff, 1'b0);
    set_chan(5, 2'h2, 16'h999a, 16'h0100, 24'h000a00, 16'h0000, 16'hffff, 1'b0);
    set_chan(6, 2'h1, 16'h7fff, 16'h0200, 24'h000a00, 16'h0000, 16'h8000, 1'b0);
    set_chan(7, 2'h0, 16'h4000, 16'h0100, 24'h000000, 16'h0000, 16'hffff, 1'b0);
    @(posedge clk);
    chanEnable <= '1;
    wait_upd(3);
    measure(40);
    chk_chan(0, 16, 0, 0, 1'b0, 16'h6666);
    chk_chan(1, 8, 0, 0, 1'b0, 16'h3333);
    chk_chan(2, 16, 0, 0, 1'b1, 16'h6666);
    chk_chan(3, 4, 0, 0, 1'b0, 16'h1999);
    chk_chan(4, 0, 16, 0, 1'b0, 16'h6666);
    chk_chan(5, 0, 0, 16, 1'b0, 16'h6666);
    chk_chan(6, 20, 0, 0, 1'b0, 16'h8000);
    chk_chan(7, 10, 0, 0, 1'b0, 16'h4000);
    check(shootThrough, 1'b0);
    set_chan(3, 2'h1, 16'h4000, 16'h0100, 24'h000a80, 16'h0000, 16'hffff, 1'b1);
    set_chan(0, 2'h0, 16'h8000, 16'h0100, 24'h000c00, 16'h3333, 16'hffff, 1'b0);
    set_chan(6, 2'h1, 16'h4000, 16'h0200, 24'h000100, 16'h0000, 16'h8000, 1'b0);
    wait_upd(3);
    measure(84);
    check(pwmTicks[3] inside {[19:23]}, 1'b1);
    check(appliedDutyReport[3], 16'h4000);
    check(pwmTicks[6], 42);
    check(appliedDutyReport[6], 16'h8000);
    check(pwmTicks[0], 14);
    check(appliedDutyReport[0], 16'h2aaa);
    check(dirOut[0], 1'b0);
    set_chan(0, 2'h0, 16'h8000, 16'h0100, 24'h000000, 16'h3333, 16'hffff, 1'b0);
    @(posedge clk);
    chanEnable <= '0;
    wait_upd(3);
    measure(40);
    for (int i = 0; i < NUM_CHAN; i++) begin
      chk_chan(i, 0, 0, 0, i == 2, 16'h0000);
    end
    end_sim();
  end
endmodule
